// [atc_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
module atc_far_model (
  input wire logic clk_i,
  output logic cc1_o,
  output logic hw_line_o
);
  initial begin
    cc1_o = 1'b0;
    hw_line_o = 1'b0;
  end
  // push-pull lines, so the last level is really held between pulses
  task automatic idle(input logic v);
    @(posedge clk_i);
    cc1_o <= v;
    hw_line_o <= v;
  endtask
  // caller spaces pulses beyond one frame time
  task automatic pulse_cc1(input int w);
    @(posedge clk_i);
    cc1_o <= ~cc1_o;
    repeat (w) @(posedge clk_i);
    cc1_o <= ~cc1_o;
  endtask
  task automatic pulse_hw(input int w);
    @(posedge clk_i);
    hw_line_o <= ~hw_line_o;
    repeat (w) @(posedge clk_i);
    hw_line_o <= ~hw_line_o;
  endtask
endmodule
`default_nettype wire

// [atc_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module atc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] din_i,
  output logic [W-1:0] dout_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= '0;
      dout_o <= '0;
    end else begin
      meta_reg <= din_i;
      dout_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// [atc_trigger_ctrl.sv]
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
package atc_pkg;
  localparam int CLK_MHZ = 40;
  localparam int AW = 8;
  localparam int TW = 24;
  localparam int DW = 16;

  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_CMD = 8'h04;
  localparam logic [AW-1:0] OFS_EXPOSURE = 8'h08;
  localparam logic [AW-1:0] OFS_PERIOD = 8'h0c;
  localparam logic [AW-1:0] OFS_READOUT = 8'h10;
  localparam logic [AW-1:0] OFS_DEBOUNCE = 8'h14;
  localparam logic [AW-1:0] OFS_USER_LINE = 8'h18;
  localparam logic [AW-1:0] OFS_STATUS = 8'h1c;

  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam int CTRL_POL_BIT = 3;
  localparam int CTRL_PW_BIT = 4;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_SOFT_BIT = 2;
  localparam int USER_LINE_BIT = 0;
  localparam int STAT_FCNT_LSB = 16;

  localparam logic CTRL_EXT_RST = 1'b0;
  localparam logic CTRL_POL_RST = 1'b1;
  localparam logic CTRL_PW_RST = 1'b0;
  localparam logic WAIT_RST = 1'b1;

  localparam int EXP_RST_US = 100;
  localparam int EXP_RST_CYC = EXP_RST_US * CLK_MHZ;
  localparam int READOUT_RST_US = 50;
  localparam int READOUT_RST_CYC = READOUT_RST_US * CLK_MHZ;
  localparam int PERIOD_RST_US = 1000;
  localparam int PERIOD_RST_CYC = PERIOD_RST_US * CLK_MHZ;
  localparam int DEB_RST_US = 1;
  localparam int DEB_RST_CYC = DEB_RST_US * CLK_MHZ;

  typedef enum logic [1:0] {SRC_SOFT, SRC_USER, SRC_CC1, SRC_HW} atc_src_t;
  typedef enum logic [1:0] {ST_WAIT, ST_EXPOSE, ST_READOUT} atc_phase_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } atc_bus_req_t;

  typedef struct packed {
    logic ext_en;
    atc_src_t src;
    logic pol_rise;
    logic pw_mode;
    logic [TW-1:0] exp_time;
    logic [TW-1:0] period;
    logic [TW-1:0] readout;
    logic [DW-1:0] deb_w;
    logic user_line;
    logic acq_en;
    logic stop_pend;
    atc_phase_t phase;
    logic [TW-1:0] cnt;
    logic [TW-1:0] fr_cnt;
    logic [DW-1:0] deb_cnt;
    logic deb_level;
    logic act_prev;
    logic strobe;
    logic waiting;
    logic frame_start;
    logic [15:0] frame_cnt;
    logic [31:0] rdata;
  } atc_state_t;
endpackage

module atc_trigger_ctrl #(
  parameter int PERIOD_RST = atc_pkg::PERIOD_RST_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire atc_pkg::atc_bus_req_t bus_i,
  output logic [31:0] rdata_o,
  input wire logic cc1_i,
  input wire logic hw_input_line_i,
  output logic strobe_o,
  output logic frame_start_o,
  output logic acq_active_o,
  output logic waiting_o
);
  atc_pkg::atc_state_t st_reg;
  atc_pkg::atc_state_t st_next;
  logic [1:0] pins_sync;
  logic cc1_sync;
  logic hw_sync;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_soft;
  logic lvl;
  logic act;
  logic ext_edge;
  logic int_trig;
  logic trig;
  logic pw_active;

  // pins cross in from outside the clock domain
  atc_sync #(.W(2)) u_pin_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .din_i({cc1_i, hw_input_line_i}),
    .dout_o(pins_sync)
  );
  assign cc1_sync = pins_sync[1];
  assign hw_sync = pins_sync[0];

  always_comb begin
    st_next = st_reg;
    st_next.frame_start = 1'b0;
    st_next.rdata = '0;
    cmd_start = bus_i.wr && bus_i.addr == atc_pkg::OFS_CMD && bus_i.wdata[atc_pkg::CMD_START_BIT];
    cmd_stop = bus_i.wr && bus_i.addr == atc_pkg::OFS_CMD && bus_i.wdata[atc_pkg::CMD_STOP_BIT];
    cmd_soft = bus_i.wr && bus_i.addr == atc_pkg::OFS_CMD && bus_i.wdata[atc_pkg::CMD_SOFT_BIT];

    if (bus_i.wr) begin
      case (bus_i.addr)
        atc_pkg::OFS_CTRL: begin
          st_next.ext_en = bus_i.wdata[atc_pkg::CTRL_EXT_BIT];
          st_next.src = atc_pkg::atc_src_t'(bus_i.wdata[atc_pkg::CTRL_SRC_LSB +: 2]);
          st_next.pol_rise = bus_i.wdata[atc_pkg::CTRL_POL_BIT];
          st_next.pw_mode = bus_i.wdata[atc_pkg::CTRL_PW_BIT];
        end
        atc_pkg::OFS_EXPOSURE: st_next.exp_time = bus_i.wdata[atc_pkg::TW-1:0];
        atc_pkg::OFS_PERIOD: st_next.period = bus_i.wdata[atc_pkg::TW-1:0];
        atc_pkg::OFS_READOUT: st_next.readout = bus_i.wdata[atc_pkg::TW-1:0];
        atc_pkg::OFS_DEBOUNCE: st_next.deb_w = bus_i.wdata[atc_pkg::DW-1:0];
        atc_pkg::OFS_USER_LINE: st_next.user_line = bus_i.wdata[atc_pkg::USER_LINE_BIT];
        default: ;
      endcase
    end

    // debounce: level follows the pin only after it held a new value for deb_w cycles
    if (hw_sync != st_reg.deb_level) begin
      if ({1'b0, st_reg.deb_cnt} + 17'h00001 >= {1'b0, st_reg.deb_w}) begin
        st_next.deb_level = hw_sync;
        st_next.deb_cnt = '0;
      end else begin
        st_next.deb_cnt = st_reg.deb_cnt + 16'h0001;
      end
    end else begin
      st_next.deb_cnt = '0;
    end

    case (st_reg.src)
      atc_pkg::SRC_USER: lvl = st_reg.user_line;
      atc_pkg::SRC_CC1: lvl = cc1_sync;
      atc_pkg::SRC_HW: lvl = st_reg.deb_level;
      default: lvl = ~st_reg.pol_rise;
    endcase
    act = st_reg.pol_rise ? lvl : ~lvl;
    st_next.act_prev = act;
    // software trigger is an event, not a level: one command, one edge
    ext_edge = (st_reg.src == atc_pkg::SRC_SOFT) ? cmd_soft : (act & ~st_reg.act_prev);
    pw_active = st_reg.ext_en && st_reg.pw_mode && st_reg.src != atc_pkg::SRC_SOFT;

    // period counted from frame start; a frame longer than the period holds the
    // next trigger back until waiting, which caps the rate at the maximum
    if (st_reg.acq_en && st_reg.fr_cnt != '1) begin
      st_next.fr_cnt = st_reg.fr_cnt + 24'h000001;
    end
    int_trig = ({1'b0, st_reg.fr_cnt} + 25'h0000001 >= {1'b0, st_reg.period});
    trig = (st_reg.ext_en ? ext_edge : int_trig) && !cmd_stop;

    case (st_reg.phase)
      atc_pkg::ST_WAIT: begin
        // an external trigger edge outside this state falls through and is lost; the internal trigger stays asserted
        if (st_reg.acq_en && trig) begin
          st_next.phase = atc_pkg::ST_EXPOSE;
          st_next.cnt = st_reg.exp_time;
          st_next.fr_cnt = '0;
          st_next.frame_start = 1'b1;
          st_next.frame_cnt = st_reg.frame_cnt + 16'h0001;
        end
      end
      atc_pkg::ST_EXPOSE: begin
        if (pw_active ? !act : (st_reg.cnt <= 24'h000001)) begin
          st_next.phase = atc_pkg::ST_READOUT;
          st_next.cnt = st_reg.readout;
        end else begin
          st_next.cnt = st_reg.cnt - 24'h000001;
        end
      end
      atc_pkg::ST_READOUT: begin
        if (st_reg.cnt <= 24'h000001) begin
          st_next.phase = atc_pkg::ST_WAIT;
          if (st_reg.stop_pend) begin
            st_next.acq_en = 1'b0;
            st_next.stop_pend = 1'b0;
          end
        end else begin
          st_next.cnt = st_reg.cnt - 24'h000001;
        end
      end
      default: st_next.phase = atc_pkg::ST_WAIT;
    endcase

    if (cmd_start) begin
      st_next.acq_en = 1'b1;
      st_next.stop_pend = 1'b0;
    end
    if (cmd_stop && st_reg.acq_en) begin
      // a stop in the last readout cycle lands in waiting, so it must not stay pending
      if (st_next.phase == atc_pkg::ST_WAIT) begin
        st_next.acq_en = 1'b0;
        st_next.stop_pend = 1'b0;
      end else begin
        st_next.stop_pend = 1'b1;
        st_next.acq_en = 1'b1;
      end
    end

    st_next.strobe = (st_next.phase == atc_pkg::ST_EXPOSE);
    st_next.waiting = (st_next.phase == atc_pkg::ST_WAIT);

    if (bus_i.rd) begin
      case (bus_i.addr)
        atc_pkg::OFS_CTRL: st_next.rdata = {27'h0000000, st_reg.pw_mode, st_reg.pol_rise, st_reg.src, st_reg.ext_en};
        atc_pkg::OFS_EXPOSURE: st_next.rdata = {8'h00, st_reg.exp_time};
        atc_pkg::OFS_PERIOD: st_next.rdata = {8'h00, st_reg.period};
        atc_pkg::OFS_READOUT: st_next.rdata = {8'h00, st_reg.readout};
        atc_pkg::OFS_DEBOUNCE: st_next.rdata = {16'h0000, st_reg.deb_w};
        atc_pkg::OFS_USER_LINE: st_next.rdata = {31'h00000000, st_reg.user_line};
        atc_pkg::OFS_STATUS: begin
          st_next.rdata = {st_reg.frame_cnt, 11'h000, st_reg.stop_pend,
                           st_reg.phase == atc_pkg::ST_READOUT, st_reg.phase == atc_pkg::ST_EXPOSE,
                           st_reg.phase == atc_pkg::ST_WAIT && st_reg.acq_en, st_reg.acq_en};
        end
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
      st_reg.ext_en <= atc_pkg::CTRL_EXT_RST;
      st_reg.src <= atc_pkg::SRC_SOFT;
      st_reg.pol_rise <= atc_pkg::CTRL_POL_RST;
      st_reg.pw_mode <= atc_pkg::CTRL_PW_RST;
      st_reg.exp_time <= atc_pkg::TW'(atc_pkg::EXP_RST_CYC);
      st_reg.period <= atc_pkg::TW'(PERIOD_RST);
      st_reg.readout <= atc_pkg::TW'(atc_pkg::READOUT_RST_CYC);
      st_reg.deb_w <= atc_pkg::DW'(atc_pkg::DEB_RST_CYC);
      st_reg.phase <= atc_pkg::ST_WAIT;
      st_reg.waiting <= atc_pkg::WAIT_RST;
      st_reg.act_prev <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;
  assign strobe_o = st_reg.strobe;
  assign frame_start_o = st_reg.frame_start;
  assign acq_active_o = st_reg.acq_en;
  assign waiting_o = st_reg.waiting;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_NO_START_WITHOUT_ENABLE: assert property (
    st_reg.frame_start |-> $past(st_reg.acq_en)
  ) else $error("exposure began without acquisition enable");
  AST_ENABLE_PERSISTS: assert property (
    st_reg.acq_en && !st_reg.stop_pend && !cmd_stop |=> st_reg.acq_en
  ) else $error("acquisition enable dropped without stop");
  AST_STOP_IDLE: assert property (
    cmd_stop && !cmd_start && st_reg.phase == atc_pkg::ST_WAIT |=> !st_reg.acq_en && !st_reg.strobe
  ) else $error("stop in waiting state did not clear enable");
  AST_STOP_IN_FRAME: assert property (
    cmd_stop && st_reg.acq_en && st_reg.phase != atc_pkg::ST_WAIT &&
      !(st_reg.phase == atc_pkg::ST_READOUT && st_reg.cnt <= 24'h000001) |=>
      st_reg.acq_en throughout (st_reg.phase != atc_pkg::ST_WAIT)[*1]
  ) else $error("stop during frame cut the frame short");
  AST_NO_PENDING_IN_WAIT: assert property (
    st_reg.phase == atc_pkg::ST_WAIT |-> !st_reg.stop_pend
  ) else $error("stop still pending after the frame ended");
  AST_WAIT_FLAG: assert property (
    st_reg.waiting == (st_reg.phase == atc_pkg::ST_WAIT)
  ) else $error("waiting output disagrees with phase");
  AST_PULSE_WIDTH_END: assert property (
    st_reg.phase == atc_pkg::ST_EXPOSE && pw_active && !act |=> st_reg.phase == atc_pkg::ST_READOUT && !st_reg.strobe
  ) else $error("pulse width exposure did not end on inactive level");
  AST_TIMED_END: assert property (
    st_reg.phase == atc_pkg::ST_EXPOSE && !pw_active && st_reg.cnt <= 24'h000001 |=> !st_reg.strobe
  ) else $error("timed exposure overran its count");
  AST_STAY_STOPPED: assert property (
    !st_reg.acq_en && !cmd_start |=> !st_reg.acq_en ##0 !st_reg.frame_start
  ) else $error("acquisition resumed without start");
  AST_ONLY_FROM_WAIT: assert property (
    st_reg.frame_start |-> $past(st_reg.phase) == atc_pkg::ST_WAIT && st_reg.phase == atc_pkg::ST_EXPOSE
  ) else $error("frame started outside waiting state");
  AST_SOFT_TRIGGER: assert property (
    cmd_soft && !cmd_stop && st_reg.ext_en && st_reg.src == atc_pkg::SRC_SOFT && st_reg.acq_en &&
      st_reg.phase == atc_pkg::ST_WAIT |=> st_reg.frame_start ##1 !st_reg.frame_start
  ) else $error("software trigger did not start exactly one frame");
  AST_FREE_RUN: assert property (
    !st_reg.ext_en && st_reg.acq_en && !cmd_stop && st_reg.phase == atc_pkg::ST_WAIT && int_trig |=>
      st_reg.frame_start
  ) else $error("free run trigger not generated");
  AST_STROBE_EXPOSURE: assert property (
    st_reg.frame_start |-> st_reg.strobe && $rose(st_reg.strobe)
  ) else $error("strobe not aligned to exposure start");
  AST_DEBOUNCE: assert property (
    $changed(st_reg.deb_level) |-> $past(st_reg.deb_cnt) + 16'h0001 >= $past(st_reg.deb_w)
  ) else $error("debounced level changed before minimum width");
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [1:0] src; logic pol; logic [23:0] ex; logic [23:0] want;} atc_row_t;
  localparam atc_row_t ROWS [6] = '{
    '{2'h0, 1'b1, 24'h3, 24'h3},
    '{2'h1, 1'b1, 24'h5, 24'h5},
    '{2'h2, 1'b1, 24'h2, 24'h2},
    '{2'h3, 1'b1, 24'h4, 24'h4},
    '{2'h2, 1'b0, 24'h6, 24'h6},
    '{2'h3, 1'b0, 24'h0, 24'h1}};
  localparam logic [7:0] A_CTRL = atc_pkg::OFS_CTRL;
  localparam logic [7:0] A_CMD = atc_pkg::OFS_CMD;
  localparam logic [7:0] A_EXP = atc_pkg::OFS_EXPOSURE;
  logic clk_i, resetn_i, cc1, hwl, strobe_o, frame_start_o, acq_active_o, waiting_o;
  logic [31:0] rdata_o, rv;
  atc_pkg::atc_bus_req_t bus;
  int mismatches = 0, comparisons = 0, frames = 0, cur = 0, last_w = 0, f0, i;
  atc_trigger_ctrl #(.PERIOD_RST(20)) atc_trigger_ctrl_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .bus_i(bus), .rdata_o(rdata_o), .cc1_i(cc1), .hw_input_line_i(hwl), .strobe_o(strobe_o),
    .frame_start_o(frame_start_o), .acq_active_o(acq_active_o), .waiting_o(waiting_o));
  atc_far_model atc_far_model_inst (.clk_i(clk_i), .cc1_o(cc1), .hw_line_o(hwl));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // sampled mid-cycle so registered outputs have settled
  always @(negedge clk_i) begin
    if (frame_start_o === 1'b1) frames++;
    if (strobe_o === 1'b1) cur++;
    else if (cur != 0) begin
      last_w = cur;
      cur = 0;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic fire(input logic [1:0] s, input logic p);
    case (s)
      2'h0: wr(A_CMD, 32'h4);
      2'h1: begin
        wr(atc_pkg::OFS_USER_LINE, {31'h0, p});
        wr(atc_pkg::OFS_USER_LINE, {31'h0, ~p});
      end
      2'h2: atc_far_model_inst.pulse_cc1(4);
      default: atc_far_model_inst.pulse_hw(8);
    endcase
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    mismatches++;
    finish_test;
  end
  initial begin
    resetn_i = 1'b0;
    bus = '0;
    cyc(16);
    resetn_i <= 1'b1;
    rd(A_CTRL, rv);
    chk("ctrl", rv, 32'h8);
    rd(A_EXP, rv);
    chk("exposure", rv, 32'hfa0);
    rd(atc_pkg::OFS_PERIOD, rv);
    chk("period", rv, 32'h14);
    rd(atc_pkg::OFS_DEBOUNCE, rv);
    chk("debounce", rv, 32'h28);
    rd(A_CMD, rv);
    chk("cmd", rv, 32'h0);
    rd(8'h20, rv);
    chk("unmapped", rv, 32'h0);
    cyc(60);
    chk("free run before start", frames, 0);
    $display("reset test done");
    wr(atc_pkg::OFS_READOUT, 32'h3);
    wr(atc_pkg::OFS_DEBOUNCE, 32'h4);
    // trigger mode first, or the start would free-run the long reset exposure
    wr(A_CTRL, 32'h9);
    wr(A_CMD, 32'h1);
    for (i = 0; i < 6; i++) begin
      atc_far_model_inst.idle(~ROWS[i].pol);
      wr(atc_pkg::OFS_USER_LINE, {31'h0, ~ROWS[i].pol});
      wr(A_EXP, {8'h0, ROWS[i].ex});
      wr(A_CTRL, {27'h0, 1'b0, ROWS[i].pol, ROWS[i].src, 1'b1});
      cyc(30);
      f0 = frames;
      fire(ROWS[i].src, ROWS[i].pol);
      cyc(40);
      chk("frames", frames - f0, 1);
      chk("strobe width", last_w, ROWS[i].want);
    end
    $display("source table done");
    atc_far_model_inst.idle(~ROWS[0].pol);
    wr(A_CTRL, 32'h9);
    wr(A_EXP, 32'h14);
    cyc(30);
    f0 = frames;
    fire(2'h0, 1'b1);
    fire(2'h0, 1'b1);
    cyc(5);
    fire(2'h0, 1'b1);
    cyc(40);
    @(negedge clk_i);
    chk("dropped triggers", frames - f0, 1);
    chk("waiting again", waiting_o, 1'b1);
    wr(A_CTRL, 32'h1d);
    cyc(30);
    atc_far_model_inst.pulse_cc1(10);
    cyc(30);
    chk("pulse width", 32'(last_w >= 9 && last_w <= 11), 1);
    wr(A_CTRL, 32'h19);
    fire(2'h0, 1'b1);
    cyc(40);
    chk("soft forces timed", last_w, 20);
    wr(A_CTRL, 32'hf);
    cyc(30);
    f0 = frames;
    atc_far_model_inst.pulse_hw(2);
    cyc(30);
    chk("short pulse", frames - f0, 0);
    fire(2'h3, 1'b1);
    cyc(40);
    chk("valid pulse", frames - f0, 1);
    $display("trigger tests done");
    wr(A_CTRL, 32'h9);
    cyc(30);
    f0 = frames;
    fire(2'h0, 1'b1);
    cyc(3);
    wr(A_CMD, 32'h2);
    @(negedge clk_i);
    chk("stop in frame", acq_active_o, 1'b1);
    cyc(40);
    @(negedge clk_i);
    chk("stop done", acq_active_o, 1'b0);
    chk("frame finished", last_w, 20);
    fire(2'h0, 1'b1);
    cyc(30);
    chk("after stop", frames - f0, 1);
    wr(A_CMD, 32'h1);
    cyc(3);
    @(negedge clk_i);
    chk("start again", acq_active_o, 1'b1);
    wr(A_CMD, 32'h2);
    @(negedge clk_i);
    chk("stop idle", acq_active_o, 1'b0);
    $display("stop tests done");
    wr(A_CTRL, 32'h8);
    wr(A_EXP, 32'h3);
    wr(A_CMD, 32'h1);
    f0 = frames;
    cyc(200);
    chk("free rate", 32'(frames - f0 >= 9 && frames - f0 <= 11), 1);
    wr(A_EXP, 32'h1e);
    f0 = frames;
    cyc(330);
    chk("max rate", 32'(frames - f0 >= 9 && frames - f0 <= 11), 1);
    $display("free run done");
    @(posedge clk_i);
    resetn_i <= 1'b0;
    @(negedge clk_i);
    chk("reset strobe", strobe_o, 1'b0);
    chk("reset enable", acq_active_o, 1'b0);
    chk("reset waiting", waiting_o, 1'b1);
    cyc(16);
    resetn_i <= 1'b1;
    f0 = frames;
    cyc(60);
    chk("stopped after reset", frames - f0, 0);
    $display("mid-run reset done");
    finish_test;
  end
endmodule
`default_nettype wire
